// file: hdl/local_adjust_menu.v
// local adjustment menu driven by two magnetic reed switches
`timescale 1ns/1ps
`include "menu_consts.vh"

// Overview of operation
// (R1) rotate hold lights entry flag first
// (R2) pick 2 s, release 2 s, pick 2 s again enters
// (R3) banner holds 5 s; rotate opens tree
// (R4) rotate hold steps options cyclically
// (R5) pick selects the shown option
// (R6) tree usable only with tree jumper
// (R7) simulation only with simulation jumper
// (R8) no display fitted refuses entry
// (R9) pick edits by arrow; rotate flips down
// (R10) bus address kept within 3 to 126
// (R11) selector codes 0, 1 default, 127
// (R12) code 127 answers user identity value
// (R13) high byte first, low byte second
// (R14) six slots: block, index, sub-item
// (R15) index relative within chosen block
// (R16) sub-item used only for structures
// (R17) display cycles first N slots
// (R18) slot edits apply only on commit
// (R19) open at tag first, else last
// (R20) factory reinit restores selector 1
// (R21) store 5 s; identity after power cycle
// (R22) reed inputs synchronised and debounced
module local_adjust_menu #(
    parameter integer DWELL_CYC  = `MS_CYCLES(`DWELL_MS),
    parameter integer BANNER_CYC = `MS_CYCLES(`BANNER_MS),
    parameter integer STORE_CYC  = `MS_CYCLES(`STORE_MS),
    parameter integer STEP_CYC   = `MS_CYCLES(`STEP_MS),
    parameter integer DEB_CYC    = `US_CYCLES(`DEBOUNCE_US),
    parameter [15:0]  MAKER_ID   = 16'h1234 // arbitrary value
) (
    input  wire        sys_clk_i,
    input  wire        rstn_i,
    input  wire        rotate_pin_i,
    input  wire        pick_pin_i,
    input  wire        tree_enable_jumper_i,
    input  wire        simulation_enable_jumper_i,
    input  wire        display_present_i,
    input  wire        factory_reinit_command_i,
    input  wire        slot_is_struct_i,
    output wire        adjust_entry_flag_o,
    output wire        local_entry_banner_o,
    output wire        tree_open_o,
    output wire [3:0]  option_o,
    output wire        arrow_down_o,
    output wire [7:0]  edit_lower_o,
    output wire [7:0]  edit_upper_o,
    output wire [7:0]  bus_address_o,
    output wire [7:0]  identity_selector_o,
    output wire [15:0] active_ident_o,
    output wire        store_busy_o,
    output wire        simulation_on_o,
    output wire [2:0]  shown_slot_o,
    output wire [2:0]  shown_block_o,
    output wire [7:0]  shown_param_o,
    output wire [7:0]  shown_item_o
);
    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_FLAG   = 3'h1;
    localparam [2:0] ST_PICK1  = 3'h2;
    localparam [2:0] ST_GAP    = 3'h3;
    localparam [2:0] ST_PICK2  = 3'h4;
    localparam [2:0] ST_BANNER = 3'h5;
    localparam [2:0] ST_TREE   = 3'h6;

    wire rot;
    wire pick;
    reed_filter #(.STABLE(DEB_CYC)) u_rot (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (rotate_pin_i),
        .level_o   (rot)
    ); // (R22)
    reed_filter #(.STABLE(DEB_CYC)) u_pick (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .pin_i     (pick_pin_i),
        .level_o   (pick)
    ); // (R22)

    reg  [2:0]  st_ff;
    reg  [31:0] tmr_ff;
    reg  [31:0] step_ff;
    reg         rot_d_ff;
    reg         pick_d_ff;
    reg  [3:0]  opt_ff;
    reg         used_ff;
    reg         down_ff;
    reg  [7:0]  lower_ff;
    reg  [7:0]  upper_ff;
    reg  [7:0]  addr_ff;
    reg  [7:0]  identity_selector_ff;
    reg  [7:0]  idhi_ff;
    reg  [7:0]  idlo_ff;
    reg  [31:0] store_ff;
    reg         sim_ff;
    reg  [2:0]  eslot_ff;
    reg  [2:0]  eblk_ff;
    reg  [7:0]  eprm_ff;
    reg  [7:0]  eitm_ff;
    reg  [2:0]  slot_cycle_count_ff;
    reg  [2:0]  blk_ff [0:`SLOTS-1];
    reg  [7:0]  prm_ff [0:`SLOTS-1];
    reg  [7:0]  itm_ff [0:`SLOTS-1];
    reg  [2:0]  shown_ff;
    reg  [31:0] show_tmr_ff;
    integer     i;

    wire rot_rise  = rot & ~rot_d_ff;
    wire pick_rise = pick & ~pick_d_ff;
    wire in_tree   = (st_ff == ST_TREE);
    // a held pick repeats at step rate so values run while kept in place
    wire pick_tick = in_tree & pick & (pick_rise | (step_ff == STEP_CYC - 1));
    wire rot_tick  = in_tree & rot & (step_ff == STEP_CYC - 1);

    function [7:0] bump;
        input [7:0] v;
        input       dn;
        input [7:0] lo;
        input [7:0] hi;
        begin
            if (dn) begin
                bump = (v > lo) ? v - 8'h01 : v;
            end else begin
                bump = (v < hi) ? v + 8'h01 : v;
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // entry sequence and tree navigation
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_ff     <= ST_IDLE;
            tmr_ff    <= 32'h0000_0000;
            step_ff   <= 32'h0000_0000;
            rot_d_ff  <= 1'b0;
            pick_d_ff <= 1'b0;
            opt_ff    <= `OPT_TAG;
            used_ff   <= 1'b0;
            down_ff   <= 1'b0;
        end else begin
            rot_d_ff  <= rot;
            pick_d_ff <= pick;
            if ((rot | pick) && step_ff != STEP_CYC - 1) begin
                step_ff <= step_ff + 32'h0000_0001;
            end else begin
                step_ff <= 32'h0000_0000;
            end
            case (st_ff)
                ST_IDLE: begin
                    if (rot && display_present_i && tree_enable_jumper_i) begin // (R8) (R6)
                        st_ff <= ST_FLAG; // (R1)
                    end
                end
                ST_FLAG: begin
                    tmr_ff <= 32'h0000_0000;
                    if (pick_rise) begin
                        st_ff <= ST_PICK1; // (R1)
                    end
                end
                ST_PICK1: begin
                    tmr_ff <= pick ? tmr_ff + 32'h0000_0001 : 32'h0000_0000;
                    if (!pick) begin
                        st_ff <= (tmr_ff >= DWELL_CYC) ? ST_GAP : ST_FLAG; // (R2)
                    end
                end
                ST_GAP: begin
                    tmr_ff <= tmr_ff + 32'h0000_0001;
                    if (pick) begin
                        st_ff  <= (tmr_ff >= DWELL_CYC) ? ST_PICK2 : ST_FLAG; // (R2)
                        tmr_ff <= 32'h0000_0000;
                    end
                end
                ST_PICK2: begin
                    tmr_ff <= pick ? tmr_ff + 32'h0000_0001 : 32'h0000_0000;
                    if (!pick) begin
                        st_ff <= (tmr_ff >= DWELL_CYC) ? ST_BANNER : ST_FLAG; // (R2)
                    end
                end
                ST_BANNER: begin
                    tmr_ff <= tmr_ff + 32'h0000_0001;
                    if (rot_rise) begin
                        st_ff   <= ST_TREE; // (R3)
                        used_ff <= 1'b1;
                        down_ff <= 1'b0;
                        // option kept from last session, tag on first use
                        opt_ff  <= used_ff ? opt_ff : `OPT_TAG; // (R19) (R4)
                    end else if (tmr_ff >= BANNER_CYC) begin
                        st_ff <= ST_IDLE; // (R3)
                    end
                end
                ST_TREE: begin
                    if (rot_rise) begin
                        down_ff <= 1'b1; // (R9)
                    end else if (rot_tick) begin
                        opt_ff  <= (opt_ff == `OPT_LAST) ? `OPT_TAG : opt_ff + 4'h1; // (R4)
                        down_ff <= 1'b0;
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
            // losing display or jumper aborts entry as well as the open tree
            if (!display_present_i || !tree_enable_jumper_i) begin
                st_ff <= ST_IDLE; // (R8) (R6)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // parameter editing, slots and identity
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lower_ff <= 8'h00;
            upper_ff <= 8'hFF;
            addr_ff  <= `ADDR_RESET;
            identity_selector_ff <= `IDENTITY_SELECTOR_MAKER; // (R11)
            idhi_ff  <= 8'h00;
            idlo_ff  <= 8'h00;
            store_ff <= 32'h0000_0000;
            sim_ff   <= 1'b0;
            eslot_ff <= 3'h0;
            eblk_ff  <= 3'h0;
            eprm_ff  <= 8'h00;
            eitm_ff  <= 8'h00;
            slot_cycle_count_ff  <= 3'h1;
            for (i = 0; i < `SLOTS; i = i + 1) begin
                blk_ff[i] <= 3'h0;
                prm_ff[i] <= 8'h00;
                itm_ff[i] <= 8'h00;
            end
        end else begin
            if (store_ff != 32'h0000_0000) begin
                store_ff <= store_ff - 32'h0000_0001; // (R21)
            end
            if (!simulation_enable_jumper_i) begin
                sim_ff <= 1'b0; // (R7)
            end
            if (factory_reinit_command_i) begin
                identity_selector_ff <= `IDENTITY_SELECTOR_MAKER; // (R20)
                store_ff <= STORE_CYC;
            end else if (pick_tick) begin
                case (opt_ff)
                    `OPT_LOWER: lower_ff <= bump(lower_ff, down_ff, 8'h00, 8'hFF); // (R9)
                    `OPT_UPPER: upper_ff <= bump(upper_ff, down_ff, 8'h00, 8'hFF); // (R9)
                    `OPT_ADDR:  addr_ff  <= bump(addr_ff, down_ff, `ADDR_MIN, `ADDR_MAX); // (R10)
                    `OPT_IDENTITY_SELECTOR: begin
                        // only the three legal codes are reachable (R11)
                        if (down_ff) begin
                            identity_selector_ff <= (identity_selector_ff == `IDENTITY_SELECTOR_USER) ? `IDENTITY_SELECTOR_MAKER : `IDENTITY_SELECTOR_PROFILE;
                        end else begin
                            identity_selector_ff <= (identity_selector_ff == `IDENTITY_SELECTOR_PROFILE) ? `IDENTITY_SELECTOR_MAKER : `IDENTITY_SELECTOR_USER;
                        end
                        store_ff <= STORE_CYC; // (R21)
                    end
                    `OPT_IDHI:  idhi_ff  <= bump(idhi_ff, down_ff, 8'h00, 8'hFF); // (R13)
                    `OPT_IDLO:  idlo_ff  <= bump(idlo_ff, down_ff, 8'h00, 8'hFF); // (R13)
                    `OPT_SLOT:  eslot_ff <= (eslot_ff == `SLOTS - 1) ? 3'h0 : eslot_ff + 3'h1; // (R14)
                    `OPT_BLOCK: eblk_ff  <= eblk_ff + 3'h1; // (R15)
                    `OPT_SLOT_PARAM_INDEX:  eprm_ff  <= bump(eprm_ff, down_ff, 8'h00, 8'hFF); // (R15)
                    `OPT_ITEM:  eitm_ff  <= bump(eitm_ff, down_ff, 8'h00, 8'hFF); // (R16)
                    `OPT_SLOT_CYCLE_COUNT:  slot_cycle_count_ff  <= (slot_cycle_count_ff == `SLOTS) ? 3'h1 : slot_cycle_count_ff + 3'h1; // (R17)
                    `OPT_COMMIT: begin
                        blk_ff[eslot_ff] <= eblk_ff; // (R18)
                        prm_ff[eslot_ff] <= eprm_ff;
                        itm_ff[eslot_ff] <= slot_is_struct_i ? eitm_ff : 8'h00; // (R16)
                    end
                    `OPT_SIM:   sim_ff <= simulation_enable_jumper_i & ~sim_ff; // (R7)
                    default:    sim_ff <= sim_ff & simulation_enable_jumper_i;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus identity latched once at power-up from the stored copy, which a
    // power cycle keeps; the working selector restarts at its default
    reg        ident_done_ff;
    reg [15:0] bus_ident_ff;
    reg [23:0] nv_ff = {`IDENTITY_SELECTOR_MAKER, 16'h0000};
    always @(posedge sys_clk_i) begin
        if (store_ff == 32'h0000_0001) begin
            nv_ff <= {identity_selector_ff, idhi_ff, idlo_ff}; // (R21)
        end
    end
    wire [15:0] sel_ident = (nv_ff[23:16] == `IDENTITY_SELECTOR_USER) ? nv_ff[15:0] : // (R12) (R13)
                            (nv_ff[23:16] == `IDENTITY_SELECTOR_PROFILE) ? 16'h0000 : MAKER_ID; // (R11)
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ident_done_ff <= 1'b0;
            bus_ident_ff  <= 16'h0000;
        end else begin
            ident_done_ff <= 1'b1;
            if (!ident_done_ff) begin
                bus_ident_ff <= sel_ident; // (R21)
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // normal-operation slot rotation
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shown_ff    <= 3'h0;
            show_tmr_ff <= 32'h0000_0000;
        end else if (in_tree) begin
            shown_ff    <= 3'h0;
            show_tmr_ff <= 32'h0000_0000;
        end else if (show_tmr_ff >= BANNER_CYC) begin
            show_tmr_ff <= 32'h0000_0000;
            shown_ff    <= (shown_ff + 3'h1 >= slot_cycle_count_ff) ? 3'h0 : shown_ff + 3'h1; // (R17)
        end else begin
            show_tmr_ff <= show_tmr_ff + 32'h0000_0001;
        end
    end

    assign adjust_entry_flag_o  = (st_ff != ST_IDLE); // (R1)
    assign local_entry_banner_o = (st_ff == ST_BANNER); // (R3)
    assign tree_open_o          = in_tree;
    assign option_o             = opt_ff;
    assign arrow_down_o         = down_ff;
    assign edit_lower_o         = lower_ff;
    assign edit_upper_o         = upper_ff;
    assign bus_address_o        = addr_ff;
    assign identity_selector_o  = identity_selector_ff;
    assign active_ident_o       = bus_ident_ff;
    assign store_busy_o         = (store_ff != 32'h0000_0000);
    assign simulation_on_o      = sim_ff;
    assign shown_slot_o         = shown_ff;
    assign shown_block_o        = blk_ff[shown_ff];
    assign shown_param_o        = prm_ff[shown_ff];
    assign shown_item_o         = itm_ff[shown_ff];
endmodule

// file: hdl/reed_filter.v
// synchroniser and debouncer for one reed switch input
`timescale 1ns/1ps
module reed_filter #(
    parameter integer STABLE = 2000
) (
    input  wire sys_clk_i,
    input  wire rstn_i,
    input  wire pin_i,
    output wire level_o
);
    reg        s1_ff;
    reg        s2_ff;
    reg        s3_ff;
    reg        level_ff;
    reg [15:0] cnt_ff;

    // counted change needs second and third stage to agree
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_ff    <= 1'b0;
            s2_ff    <= 1'b0;
            s3_ff    <= 1'b0;
            level_ff <= 1'b0;
            cnt_ff   <= 16'h0000;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff != s3_ff || s3_ff == level_ff) begin
                cnt_ff <= 16'h0000; // (R22)
            end else if (cnt_ff == STABLE[15:0] - 16'h0001) begin
                level_ff <= s3_ff;
                cnt_ff   <= 16'h0000;
            end else begin
                cnt_ff <= cnt_ff + 16'h0001;
            end
        end
    end
    assign level_o = level_ff;
endmodule

// file: include/menu_consts.vh
// constants for the magnetic local adjustment menu
`ifndef MENU_CONSTS_VH
`define MENU_CONSTS_VH

`define CLK_MHZ            200
`define DWELL_MS           2000
`define BANNER_MS          5000
`define STORE_MS           5000
`define STEP_MS            500
`define DEBOUNCE_US        10
`define MS_CYCLES(ms)      ((ms) * 1000 * `CLK_MHZ)
`define US_CYCLES(us)      ((us) * `CLK_MHZ)

`define ADDR_MIN           8'h03
`define ADDR_MAX           8'h7E
`define ADDR_RESET         8'h7E

`define IDENTITY_SELECTOR_PROFILE      8'h00
`define IDENTITY_SELECTOR_MAKER        8'h01
`define IDENTITY_SELECTOR_USER         8'h7F

`define OPT_TAG            4'h0
`define OPT_LOWER          4'h1
`define OPT_UPPER          4'h2
`define OPT_ADDR           4'h3
`define OPT_IDENTITY_SELECTOR          4'h4
`define OPT_IDHI           4'h5
`define OPT_IDLO           4'h6
`define OPT_SLOT           4'h7
`define OPT_BLOCK          4'h8
`define OPT_SLOT_PARAM_INDEX           4'h9
`define OPT_ITEM           4'hA
`define OPT_SLOT_CYCLE_COUNT           4'hB
`define OPT_COMMIT         4'hC
`define OPT_SIM            4'hD
`define OPT_LAST           4'hD

`define SLOTS              6

`endif

// file: sim/magnetic_local_adjust_menu_bench.sv
// self-checking bench for the local adjustment menu
`timescale 1ns/1ps
`include "menu_consts.vh"
module magnetic_local_adjust_menu_bench;
    localparam [15:0] MAKER = 16'hC3A5; // arbitrary value
    logic        sys_clk_i = 1'b0;
    logic        rstn_i    = 1'b0;
    logic        tree_jmp  = 1'b1;
    logic        sim_jmp   = 1'b0;
    logic        disp      = 1'b0;
    logic        fact      = 1'b0;
    logic        strct     = 1'b0;
    logic        rot, pick, flag, banner, tree_open, arrow, busy, sim_on;
    logic [3:0]  opt;
    logic [7:0]  lower, upper, addr, sel, v, prm, itm;
    logic [15:0] ident;
    logic [2:0]  slot, blk, b;
    integer      fails = 0;
    integer      cmp_count = 0;
    integer      i, j;
    always #2.5 sys_clk_i = ~sys_clk_i;
    reed_operator u_reed_operator (.sys_clk_i(sys_clk_i), .rotate_pin_o(rot), .pick_pin_o(pick));
    local_adjust_menu #(
        .DWELL_CYC(20), .BANNER_CYC(50), .STORE_CYC(30), .STEP_CYC(16), .DEB_CYC(4), .MAKER_ID(MAKER)
    ) u_local_adjust_menu (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .rotate_pin_i(rot), .pick_pin_i(pick),
        .tree_enable_jumper_i(tree_jmp), .simulation_enable_jumper_i(sim_jmp), .display_present_i(disp),
        .factory_reinit_command_i(fact), .slot_is_struct_i(strct), .adjust_entry_flag_o(flag),
        .local_entry_banner_o(banner), .tree_open_o(tree_open), .option_o(opt), .arrow_down_o(arrow),
        .edit_lower_o(lower), .edit_upper_o(upper), .bus_address_o(addr), .identity_selector_o(sel),
        .active_ident_o(ident), .store_busy_o(busy), .simulation_on_o(sim_on), .shown_slot_o(slot),
        .shown_block_o(blk), .shown_param_o(prm), .shown_item_o(itm)
    );
    ////////////////////
    task tick(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // waits for each step, so release lag cannot add a second one
    task step_one;
        logic [3:0] o;
        o = opt;
        u_reed_operator.press(1'b0);
        for (i = 0; i < 60 && opt === o; i++) tick(1);
        u_reed_operator.drive(1'b0, 1'b0);
        chk(opt, (o == `OPT_LAST) ? 4'h0 : o + 4'h1);
        tick(14);
    endtask
    task goto(input logic [3:0] t);
        for (j = 0; j < 16 && opt !== t; j++) step_one;
    endtask
    task probe;
        u_reed_operator.press(1'b0);
        tick(30);
        chk(flag, 1'b0);
        u_reed_operator.drive(1'b0, 1'b0);
        tick(14);
    endtask
    task enter;
        u_reed_operator.press(1'b0);
        for (i = 0; i < 40 && flag !== 1'b1; i++) tick(1);
        chk(flag, 1'b1);
        u_reed_operator.drive(1'b0, 1'b0);
        tick(14);
        u_reed_operator.act(1'b1, 25);
        tick(10);
        u_reed_operator.act(1'b1, 25);
        for (i = 0; i < 40 && banner !== 1'b1; i++) tick(1);
        chk(banner, 1'b1);
    endtask
    ////////////////////
    task t_reset;
        chk({flag, banner, tree_open, busy, sim_on}, 5'h00);
        chk(addr, `ADDR_RESET);
        chk(sel, `IDENTITY_SELECTOR_MAKER);
        chk(ident, MAKER);
    endtask
    task t_refuse;
        probe;
        disp = 1'b1;
        tree_jmp = 1'b0;
        probe;
        tree_jmp = 1'b1;
    endtask
    task t_entry;
        enter;
        for (i = 0; i < 80 && banner !== 1'b0; i++) tick(1);
        chk({banner, tree_open}, 2'b00);
        enter;
        u_reed_operator.act(1'b0, 8);
        chk(tree_open, 1'b1);
        chk(opt, `OPT_TAG);
    endtask
    task t_edit;
        step_one;
        v = lower;
        u_reed_operator.act(1'b1, 8);
        chk(lower, v + 8'h01);
        goto(`OPT_UPPER);
        u_reed_operator.act(1'b0, 8);
        u_reed_operator.act(1'b1, 8);
        chk({arrow, upper}, {1'b1, 8'hFE});
        goto(`OPT_ADDR);
        u_reed_operator.act(1'b1, 300);
        chk(addr, `ADDR_MAX);
        u_reed_operator.act(1'b0, 8);
        chk(arrow, 1'b1);
        u_reed_operator.act(1'b1, 2300);
        chk(addr, `ADDR_MIN);
    endtask
    task t_ident;
        goto(`OPT_IDENTITY_SELECTOR);
        u_reed_operator.act(1'b1, 8);
        chk(sel, `IDENTITY_SELECTOR_USER);
        chk({busy, ident}, {1'b1, MAKER});
        u_reed_operator.act(1'b0, 8);
        u_reed_operator.act(1'b1, 8);
        chk(sel, `IDENTITY_SELECTOR_MAKER);
        u_reed_operator.act(1'b1, 8);
        chk(sel, `IDENTITY_SELECTOR_PROFILE);
        fact = 1'b1;
        tick(1);
        fact = 1'b0;
        tick(1);
        chk(sel, `IDENTITY_SELECTOR_MAKER);
        for (i = 0; i < 80 && busy !== 1'b0; i++) tick(1);
        chk({busy, ident}, {1'b0, MAKER});
    endtask
    task t_commit;
        goto(`OPT_BLOCK);
        b = blk;
        u_reed_operator.act(1'b1, 8);
        chk(blk, b);
        goto(`OPT_SLOT_PARAM_INDEX);
        u_reed_operator.act(1'b1, 8);
        goto(`OPT_ITEM);
        u_reed_operator.act(1'b1, 8);
        goto(`OPT_SLOT_CYCLE_COUNT);
        u_reed_operator.act(1'b1, 8);
        goto(`OPT_COMMIT);
        u_reed_operator.act(1'b1, 8);
        chk(blk, b + 3'h1);
        chk({prm, itm}, 16'h0100);
        strct = 1'b1;
        u_reed_operator.act(1'b1, 8);
        chk(itm, 8'h01);
        chk(slot, 3'h0);
    endtask
    task t_sim;
        goto(`OPT_SIM);
        u_reed_operator.act(1'b1, 8);
        chk(sim_on, 1'b0);
        sim_jmp = 1'b1;
        u_reed_operator.act(1'b1, 8);
        chk(sim_on, 1'b1);
    endtask
    task t_close;
        goto(`OPT_IDHI);
        u_reed_operator.act(1'b1, 8);
        goto(`OPT_IDLO);
        u_reed_operator.act(1'b1, 8);
        u_reed_operator.act(1'b1, 8);
        goto(`OPT_IDENTITY_SELECTOR);
        u_reed_operator.act(1'b1, 8);
        for (i = 0; i < 80 && busy !== 1'b0; i++) tick(1);
        tree_jmp = 1'b0;
        tick(10);
        chk(tree_open, 1'b0);
        for (i = 0; i < 60 && slot === 3'h0; i++) tick(1);
        chk({slot, blk}, {3'h1, 3'h0});
        for (i = 0; i < 60 && slot === 3'h1; i++) tick(1);
        chk({slot, blk}, {3'h0, b + 3'h1});
        rstn_i = 1'b0;
        tick(3);
        rstn_i = 1'b1;
        tick(3);
        chk(ident, 16'h0102);
    endtask
    initial begin
        tick(3);
        rstn_i = 1'b1;
        tick(3);
        t_reset;
        t_refuse;
        t_entry;
        t_edit;
        t_ident;
        t_commit;
        t_sim;
        t_close;
        wrap_up;
    end
    initial begin
        repeat (40000) @(posedge sys_clk_i);
        fails++;
        wrap_up;
    end
endmodule

// file: sim/menu_checker_assertions.sv
// concurrent checks on the ports of the local adjustment menu
`timescale 1ns/1ps
`include "menu_consts.vh"
module menu_checker #(
    parameter integer BANNER_CYC = 50,
    parameter integer STORE_CYC  = 30
) (
    input wire logic        sys_clk_i,
    input wire logic        rstn_i,
    input wire logic        tree_enable_jumper_i,
    input wire logic        simulation_enable_jumper_i,
    input wire logic        display_present_i,
    input wire logic        factory_reinit_command_i,
    input wire logic        adjust_entry_flag_o,
    input wire logic        local_entry_banner_o,
    input wire logic        tree_open_o,
    input wire logic [3:0]  option_o,
    input wire logic [7:0]  bus_address_o,
    input wire logic [7:0]  identity_selector_o,
    input wire logic [15:0] active_ident_o,
    input wire logic        store_busy_o,
    input wire logic        simulation_on_o,
    input wire logic [2:0]  shown_slot_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    logic        arm_ff;
    logic [7:0]  sel_ff;
    logic [15:0] ban_cnt_ff;
    logic [15:0] busy_cnt_ff;
    ////////////////////
    // busy count restarts on each selector change, so a retrigger is legal
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            arm_ff      <= 1'b0;
            sel_ff      <= `IDENTITY_SELECTOR_MAKER;
            ban_cnt_ff  <= 16'h0000;
            busy_cnt_ff <= 16'h0000;
        end else begin
            arm_ff      <= 1'b1;
            sel_ff      <= identity_selector_o;
            ban_cnt_ff  <= local_entry_banner_o ? ban_cnt_ff + 16'h0001 : 16'h0000;
            busy_cnt_ff <= (sel_ff != identity_selector_o) ? 16'h0000 :
                           store_busy_o ? busy_cnt_ff + 16'h0001 : 16'h0000;
        end
    end
    sequence s_sel_change;
        $changed(identity_selector_o);
    endsequence
    sequence s_busy_soon;
        ##[0:1] store_busy_o;
    endsequence
    ////////////////////
    a_no_display_idle: assert property (!display_present_i && $past(!display_present_i) |->
        !adjust_entry_flag_o) else $error("entry flag without display");
    a_tree_needs_jumper: assert property (!tree_enable_jumper_i && $past(!tree_enable_jumper_i) |->
        !tree_open_o && !adjust_entry_flag_o) else $error("tree active without jumper");
    a_sim_needs_jumper: assert property (!simulation_enable_jumper_i && $past(!simulation_enable_jumper_i) |->
        !simulation_on_o) else $error("simulation on without jumper");
    a_addr_in_range: assert property (bus_address_o >= `ADDR_MIN && bus_address_o <= `ADDR_MAX)
        else $error("bus address out of range");
    a_sel_legal_code: assert property (identity_selector_o inside {`IDENTITY_SELECTOR_PROFILE, `IDENTITY_SELECTOR_MAKER, `IDENTITY_SELECTOR_USER})
        else $error("illegal selector code");
    a_reinit_sel_maker: assert property (factory_reinit_command_i |=> identity_selector_o == `IDENTITY_SELECTOR_MAKER)
        else $error("reinit did not restore selector");
    a_busy_on_change: assert property (s_sel_change |-> s_busy_soon) else $error("no store after change");
    a_busy_bounded: assert property (busy_cnt_ff <= STORE_CYC + 2) else $error("store busy too long");
    a_ident_frozen: assert property (arm_ff && $past(arm_ff) |-> $stable(active_ident_o))
        else $error("identity changed without power cycle");
    a_banner_after_flag: assert property ($rose(local_entry_banner_o) |-> $past(adjust_entry_flag_o))
        else $error("banner without entry flag");
    a_tree_after_banner: assert property ($rose(tree_open_o) |-> $past(local_entry_banner_o))
        else $error("tree opened without banner");
    a_banner_span: assert property (ban_cnt_ff <= BANNER_CYC + 2) else $error("banner held too long");
    a_option_legal: assert property (option_o <= `OPT_LAST) else $error("option code past last");
    a_slot_legal: assert property (shown_slot_o < `SLOTS) else $error("shown slot past sixth");
endmodule

bind local_adjust_menu menu_checker #(
    .BANNER_CYC(BANNER_CYC),
    .STORE_CYC (STORE_CYC)
) u_menu_checker (
    .sys_clk_i, .rstn_i, .tree_enable_jumper_i, .simulation_enable_jumper_i, .display_present_i,
    .factory_reinit_command_i, .adjust_entry_flag_o, .local_entry_banner_o, .tree_open_o, .option_o,
    .bus_address_o, .identity_selector_o, .active_ident_o, .store_busy_o, .simulation_on_o, .shown_slot_o
);

// file: sim/reed_operator.sv
// operator model working the two reed switches with a magnetic tool
`timescale 1ns/1ps
module reed_operator (
    input  wire logic sys_clk_i,
    output logic      rotate_pin_o,
    output logic      pick_pin_o
);
    initial begin
        rotate_pin_o = 1'b0;
        pick_pin_o   = 1'b0;
    end
    task automatic drive(input bit pk, input logic v);
        if (pk) pick_pin_o = v;
        else rotate_pin_o = v;
    endtask
    // contacts chatter on closing, each burst shorter than the debounce span
    task automatic press(input bit pk);
        repeat (3) begin
            @(negedge sys_clk_i) drive(pk, 1'b1);
            @(negedge sys_clk_i) drive(pk, 1'b0);
        end
        @(negedge sys_clk_i) drive(pk, 1'b1);
    endtask
    task automatic act(input bit pk, input int n);
        press(pk);
        repeat (n) @(negedge sys_clk_i);
        drive(pk, 1'b0);
        repeat (14) @(negedge sys_clk_i);
    endtask
endmodule
